// File: src/pcdz_consts.vh
`ifndef PCDZ_CONSTS_VH
`define PCDZ_CONSTS_VH

// Register indices; the byte address is four times the index
`define PCDZ_IDX_COUNTS 12'h0190
`define PCDZ_IDX_CTRL 12'h0191
`define PCDZ_IDX_ROUTE 12'h0192
`define PCDZ_IDX_STATUS 12'h0193

// Reset values
`define PCDZ_RST_COUNTS 8'h00
`define PCDZ_RST_CTRL 8'h80
`define PCDZ_RST_ROUTE 8'h00

// Cycle-count register fields
`define PCDZ_LOW_MSB 7
`define PCDZ_LOW_LSB 4
`define PCDZ_HIGH_MSB 3
`define PCDZ_HIGH_LSB 0

// Control register fields
`define PCDZ_BYPASS_BIT 7
`define PCDZ_IGNALIGN_BIT 6
`define PCDZ_FORCE_BIT 5
`define PCDZ_STARTHI_BIT 4
`define PCDZ_PHASE_MSB 3
`define PCDZ_PHASE_LSB 0

// Route register fields
`define PCDZ_DIRECT_BIT 1
`define PCDZ_DCC_DIS_BIT 0

// Source select codes
`define PCDZ_SRC_EXT 2'h0
`define PCDZ_SRC_NONE 2'h1
`define PCDZ_SRC_OSC 2'h2

`endif

// File: src/pcdz_divider.v
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`include "pcdz_consts.vh"

// What this block does
// - Output stays low for low-count plus one input cycles.
// - Output stays high for high-count plus one; both counts reset zero.
// - Bypass bit routes input straight to output; bypass by default.
// - Alignment obeyed unless ignore-alignment is set; resets zero.
// - Force bit sets a static level; needs ignore-alignment set and align_n low.
// - Start-level bit picks first level of divided clock; resets low.
// - Four-bit phase offset delays output timing; resets zero.
// - Both pair outputs fed by divider while direct-route bit is zero.
// - Direct: oscillator on 10b, external on 00b, unchanged on 01b.
// - Route bit zero disables duty correction when one; resets zero.
module pcdz_divider #(
  parameter ADDR_W = 12
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire osc_clk_level,
  input wire ext_clk_level,
  input wire [1:0] clock_source_select,
  input wire align_n,
  output reg pair_zero_output_a,
  output reg pair_zero_output_b,
  output reg duty_correction_on
);

  // Divider states, one-hot
  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_PHASE = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  // Software-visible registers
  wire [7:0] counts_q;
  wire [7:0] ctrl_q;
  wire [7:0] route_q;

  // Bus handshake
  reg [ADDR_W-1:0] word_idx;
  reg addr_ok;
  reg [7:0] rd_byte;
  wire req;
  wire do_write;
  wire accept;
  wire sel_counts;
  wire sel_ctrl;
  wire sel_route;
  wire wr_counts;
  wire wr_ctrl;
  wire wr_route;

  // Sampled source levels
  reg osc_q;
  reg ext_q;
  reg src_q;
  reg src_prev_q;
  wire in_tick;

  // Divider core
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;
  reg lvl_q;
  reg lvl_d;

  // Control field views
  wire [3:0] low_cnt;
  wire [3:0] high_cnt;
  wire bypass;
  wire ign_align;
  wire force_lvl;
  wire start_hi;
  wire [3:0] phase;
  wire direct;
  wire align_act;
  wire held;
  wire force_valid;
  reg out_d;
  wire [7:0] status_byte;
  wire [3:0] first_load;
  wire [3:0] next_load;
  wire [3:0] phase_load;
  wire cnt_zero;

  // Field extraction
  assign low_cnt = counts_q[`PCDZ_LOW_MSB:`PCDZ_LOW_LSB];
  assign high_cnt = counts_q[`PCDZ_HIGH_MSB:`PCDZ_HIGH_LSB];
  assign bypass = ctrl_q[`PCDZ_BYPASS_BIT];
  assign ign_align = ctrl_q[`PCDZ_IGNALIGN_BIT];
  assign force_lvl = ctrl_q[`PCDZ_FORCE_BIT];
  assign start_hi = ctrl_q[`PCDZ_STARTHI_BIT];
  assign phase = ctrl_q[`PCDZ_PHASE_MSB:`PCDZ_PHASE_LSB];
  assign direct = route_q[`PCDZ_DIRECT_BIT];

  // Alignment use and static forcing
  assign align_act = ~align_n;
  assign force_valid = ign_align & align_act;
  assign held = bypass | (align_act & ~ign_align);

  // Count reloads: first level after a restart, then the opposite level
  assign first_load = start_hi ? high_cnt : low_cnt;
  assign next_load = lvl_q ? low_cnt : high_cnt;
  assign phase_load = phase - 4'h1;
  assign cnt_zero = (cnt_q == 4'h0);

  // Status byte: one-hot state above the divider level
  assign status_byte = {4'h0, state_q, lvl_q};

  // Request decode
  assign req = avs_read | avs_write;
  assign do_write = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign accept = req & avs_waitrequest;

  // Word index from byte address
  always @* begin
    word_idx = {2'b00, avs_address[ADDR_W-1:2]};
    addr_ok = (avs_address[1:0] == 2'b00) &&
              (word_idx >= `PCDZ_IDX_COUNTS) &&
              (word_idx <= `PCDZ_IDX_STATUS);
  end

  // One-hot register selects and write strobes; status is read-only
  assign sel_counts = addr_ok && (word_idx == `PCDZ_IDX_COUNTS);
  assign sel_ctrl = addr_ok && (word_idx == `PCDZ_IDX_CTRL);
  assign sel_route = addr_ok && (word_idx == `PCDZ_IDX_ROUTE);
  assign wr_counts = do_write & sel_counts;
  assign wr_ctrl = do_write & sel_ctrl;
  assign wr_route = do_write & sel_route;

  // Read mux; status shows divider level and state
  always @* begin
    rd_byte = 8'h00;
    if (addr_ok) begin
      case (word_idx)
        `PCDZ_IDX_COUNTS: rd_byte = counts_q;
        `PCDZ_IDX_CTRL: rd_byte = ctrl_q;
        `PCDZ_IDX_ROUTE: rd_byte = route_q;
        `PCDZ_IDX_STATUS: rd_byte = status_byte;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Waitrequest drops for one cycle per request
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~accept;
    end
  end

  // Read data taken with the answer and held until the next one
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (accept) begin
      avs_readdata <= avs_read ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Cycle-count register, written at the edge that ends the waitrequest-low answer cycle
  pcdz_byte_reg #(
    .RST_VAL(`PCDZ_RST_COUNTS)
  ) u_counts (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(wr_counts),
    .wr_data(avs_writedata[7:0]),
    .value_q(counts_q)
  );

  // Control register; resets to bypass, start low, no phase offset
  pcdz_byte_reg #(
    .RST_VAL(`PCDZ_RST_CTRL)
  ) u_ctrl (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(wr_ctrl),
    .wr_data(avs_writedata[7:0]),
    .value_q(ctrl_q)
  );

  // Route register; the unused upper bits always read zero
  pcdz_byte_reg #(
    .RST_VAL(`PCDZ_RST_ROUTE)
  ) u_route (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(wr_route),
    .wr_data({6'h00, avs_writedata[1:0]}),
    .value_q(route_q)
  );

  // Sample both source pins for the direct routes
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      osc_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      osc_q <= osc_clk_level;
      ext_q <= ext_clk_level;
    end
  end

  // Selected divider input; no selection falls back to external
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      src_q <= 1'b0;
      src_prev_q <= 1'b0;
    end else begin
      src_q <= (clock_source_select == `PCDZ_SRC_OSC) ?
               osc_clk_level : ext_clk_level;
      src_prev_q <= src_q;
    end
  end

  // One divider input cycle per rising source edge
  assign in_tick = src_q & ~src_prev_q;

  // Divider next state
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    case (state_q)
      ST_HOLD: begin
        lvl_d = start_hi;
        if (!held) begin
          if (phase == 4'h0) begin
            state_d = ST_RUN;
            cnt_d = first_load;
          end else begin
            state_d = ST_PHASE;
            cnt_d = phase_load;
          end
        end
      end
      ST_PHASE: begin
        if (held) begin
          state_d = ST_HOLD;
        end else if (in_tick) begin
          if (cnt_zero) begin
            state_d = ST_RUN;
            cnt_d = first_load;
          end else begin
            cnt_d = cnt_q - 4'h1;
          end
        end
      end
      ST_RUN: begin
        if (held) begin
          state_d = ST_HOLD;
          lvl_d = start_hi;
        end else if (in_tick) begin
          if (cnt_zero) begin
            lvl_d = ~lvl_q;
            cnt_d = next_load;
          end else begin
            cnt_d = cnt_q - 4'h1;
          end
        end
      end
      default: begin
        state_d = ST_HOLD;
        cnt_d = 4'h0;
        lvl_d = 1'b0;
      end
    endcase
  end

  // Divider registers
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= ST_HOLD;
      cnt_q <= 4'h0;
      lvl_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
    end
  end

  // Output routing: direct path, force, bypass, then divider
  always @* begin
    if (direct && clock_source_select == `PCDZ_SRC_OSC) begin
      out_d = osc_q;
    end else if (direct && clock_source_select == `PCDZ_SRC_EXT) begin
      out_d = ext_q;
    end else if (force_valid) begin
      out_d = force_lvl;
    end else if (bypass) begin
      out_d = src_q;
    end else begin
      out_d = lvl_q;
    end
  end

  // Both outputs of the pair carry the same selected level
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pair_zero_output_a <= 1'b0;
      pair_zero_output_b <= 1'b0;
    end else begin
      pair_zero_output_a <= out_d;
      pair_zero_output_b <= out_d;
    end
  end

  // Correction flag is only reported; the output path ignores it
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      duty_correction_on <= 1'b1;
    end else begin
      duty_correction_on <= ~route_q[`PCDZ_DCC_DIS_BIT];
    end
  end

endmodule // pcdz_divider

// One software register byte with a synchronous reset value
module pcdz_byte_reg #(
  parameter [7:0] RST_VAL = 8'h00
) (
  input wire ref_clk,
  input wire rst_n,
  input wire wr_en,
  input wire [7:0] wr_data,
  output reg [7:0] value_q
);

  // Load on an accepted write, otherwise hold
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      value_q <= RST_VAL;
    end else if (wr_en) begin
      value_q <= wr_data;
    end
  end

endmodule // pcdz_byte_reg

// File: verification/pcdz_divider_asserts.sv
`timescale 1ns/1ps
module pcdz_divider_asserts #(
  parameter ADDR_W = 12
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire osc_clk_level,
  input wire ext_clk_level,
  input wire [1:0] clock_source_select,
  input wire align_n,
  input wire pair_zero_output_a,
  input wire pair_zero_output_b,
  input wire duty_correction_on
);
  // Request pending on the bus
  wire req = avs_read || avs_write;
  wire bad = avs_address > 12'h64C || avs_address < 12'h640 ||
    avs_address[1:0] != 2'h0;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Bus handshake and read data
  a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait cycle");
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for too long");
  a_idle_wait: assert property (!req |=> avs_waitrequest)
    else $error("answer without request");
  a_rdata_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data changed outside answer");
  a_rdata_upper: assert property (avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest && bad
    |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  // Output pair and reset state
  a_pair_same: assert property
    (pair_zero_output_a == pair_zero_output_b)
    else $error("pair outputs differ");
  a_reset_vals: assert property
    ($rose(rst_n) |-> duty_correction_on && !pair_zero_output_a &&
    avs_waitrequest)
    else $error("wrong state after reset");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_write: cover property (avs_write && !avs_waitrequest);
  c_pair_rise: cover property ($rose(pair_zero_output_a));
endmodule // pcdz_divider_asserts

bind pcdz_divider pcdz_divider_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

// File: verification/pcdz_load_model.sv
`timescale 1ns/1ps
module pcdz_load_model (
  input wire ref_clk,
  input wire pin,
  output logic [7:0] hi_len,
  output logic [7:0] lo_len
);
  logic [7:0] run = 8'h00;
  logic prev = 1'b0;
  // Length of the last high and low run in clock cycles
  always @(posedge ref_clk) begin
    if (pin !== prev) begin
      if (prev) hi_len <= run;
      else lo_len <= run;
      run <= 8'h01;
    end else run <= run + 8'h01;
    prev <= pin;
  end
endmodule // pcdz_load_model

// File: verification/tb_pcdz_divider.sv
`timescale 1ns/1ps
module tb_pcdz_divider;
  logic ref_clk = 0, rst_n = 0, rd = 0, wr = 0, osc = 0, ext = 0;
  logic align_n = 1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic [1:0] sel = 2'h0;
  logic [7:0] q;
  logic [7:0] tab [4] = '{8'h00, 8'h21, 8'hF0, 8'h0F};
  wire [31:0] rdata;
  wire wreq, pa, pb, dcc;
  wire [7:0] hl, ll;
  int error_cnt = 0, checks = 0, n0, n5, i;
  // Clock and the two source clocks
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) ext <= ~ext;
  always @(posedge ref_clk) if (ext) osc <= ~osc;
  pcdz_divider dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .avs_address(addr),
    .avs_read(rd),
    .avs_write(wr),
    .avs_writedata(wdata),
    .avs_byteenable(be),
    .avs_readdata(rdata),
    .avs_waitrequest(wreq),
    .osc_clk_level(osc),
    .ext_clk_level(ext),
    .clock_source_select(sel),
    .align_n(align_n),
    .pair_zero_output_a(pa),
    .pair_zero_output_b(pb),
    .duty_correction_on(dcc)
  );
  pcdz_load_model u_load (.ref_clk(ref_clk), .pin(pa), .hi_len(hl),
    .lo_len(ll));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    addr <= a;
    wdata <= {24'h00_0000, d};
    rd <= !w;
    wr <= w;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) chk(8'h00, 8'h01);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  task automatic lens(input logic [7:0] hi, input logic [7:0] lo);
    repeat (150) @(posedge ref_clk);
    chk(hl, hi);
    chk(ll, lo);
  endtask
  task automatic pin_after(input logic [7:0] exp);
    repeat (6) @(posedge ref_clk);
    chk({7'h00, pa}, exp);
    chk({7'h00, pb}, exp);
  endtask
  // Release alignment at a fixed source phase, count to first rise
  task automatic first_rise(output int n);
    @(posedge ref_clk);
    while (ext !== 1'b0) @(posedge ref_clk);
    align_n <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pa !== 1'b1 && n < 200);
    align_n <= 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    test_done();
  end
  // Test sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(12'h640, 8'h00);
    rdc(12'h644, 8'h80);
    rdc(12'h648, 8'h00);
    rdc(12'h64C, 8'h02);
    rdc(12'h700, 8'h00);
    chk({7'h00, dcc}, 8'h01);
    lens(8'h01, 8'h01);
    bus(1'b1, 12'h644, 8'h00);
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 12'h640, tab[i]);
      lens(8'(2 * (tab[i][3:0] + 1)),
        8'(2 * (tab[i][7:4] + 1)));
    end
    be <= 4'h0;
    bus(1'b1, 12'h640, 8'h33);
    be <= 4'hF;
    rdc(12'h640, 8'h0F);
    bus(1'b1, 12'h640, 8'h11);
    bus(1'b1, 12'h648, 8'h02);
    sel <= 2'h2;
    lens(8'h02, 8'h02);
    sel <= 2'h0;
    lens(8'h01, 8'h01);
    sel <= 2'h1;
    lens(8'h04, 8'h04);
    bus(1'b1, 12'h648, 8'hFD);
    rdc(12'h648, 8'h01);
    repeat (3) @(posedge ref_clk);
    chk({7'h00, dcc}, 8'h00);
    lens(8'h04, 8'h04);
    align_n <= 1'b0;
    bus(1'b1, 12'h644, 8'h60);
    pin_after(8'h01);
    bus(1'b1, 12'h644, 8'h40);
    pin_after(8'h00);
    bus(1'b1, 12'h644, 8'h10);
    pin_after(8'h01);
    bus(1'b1, 12'h644, 8'h00);
    pin_after(8'h00);
    bus(1'b1, 12'h640, 8'h00);
    first_rise(n0);
    bus(1'b1, 12'h644, 8'h05);
    first_rise(n5);
    chk(8'(n5 - n0), 8'h0A);
    test_done();
  end
endmodule // tb_pcdz_divider
